// *** shared/csr_pkg.sv ***
// Constants and types for the core special register block.
package csr_pkg;
  localparam int unsigned IDX_W   = 7;
  localparam int unsigned ADDR_W  = 9;
  localparam int unsigned IDX_LSB = 2;
  localparam int unsigned PC_W    = 10;
  localparam int unsigned STK_D   = 2;
  localparam int unsigned PORT_W  = 6;
  localparam int unsigned GEN_N   = 64;
  localparam int unsigned SEL_W   = 6;

  localparam logic [IDX_W-1:0] IDX_INDIRECT = 7'h00;
  localparam logic [IDX_W-1:0] IDX_TIMER    = 7'h01;
  localparam logic [IDX_W-1:0] IDX_PCLOW    = 7'h02;
  localparam logic [IDX_W-1:0] IDX_FLAGS    = 7'h03;
  localparam logic [IDX_W-1:0] IDX_POINTER  = 7'h04;
  localparam logic [IDX_W-1:0] IDX_PORT     = 7'h06;
  localparam logic [IDX_W-1:0] IDX_GEN_SOLO = 7'h07;
  localparam logic [IDX_W-1:0] IDX_POWER    = 7'h08;
  localparam logic [IDX_W-1:0] IDX_GEN_BASE = 7'h10;
  localparam logic [IDX_W-1:0] IDX_GEN_LAST = 7'h3f;
  localparam logic [IDX_W-1:0] IDX_TMODE    = 7'h40;
  localparam logic [SEL_W-1:0] PTR_NULL     = 6'h00;

  localparam logic [7:0]      RST_FLAGS   = 8'h18;
  localparam logic [7:0]      RST_POINTER = 8'hc0;
  localparam logic [7:0]      RST_TMODE   = 8'h3f;
  localparam logic [7:0]      RST_POWER   = 8'ha0;
  localparam logic [7:0]      POINTER_ONE = 8'hc0;
  localparam logic [7:0]      POWER_RW    = 8'he0;
  localparam logic [7:0]      TMODE_RW    = 8'h7f;
  localparam logic [5:0]      LATCH_RW    = 6'h37;
  localparam logic [7:0]      TIMER_MAX   = 8'hff;
  localparam logic [7:0]      PRESC_BASE  = 8'h02;
  localparam logic [7:0]      BYTE_ONE    = 8'h01;
  localparam logic [PC_W-1:0] PC_ONE      = 10'h001;

  localparam int unsigned FLG_CARRY = 0;
  localparam int unsigned FLG_DIGIT = 1;
  localparam int unsigned FLG_ZERO  = 2;
  localparam int unsigned FLG_PDOWN = 3;
  localparam int unsigned FLG_TOUT  = 4;
  localparam int unsigned FLG_PAGE  = 5;
  localparam int unsigned FLG_WAKE  = 7;
  localparam int unsigned TM_SRC    = 5;
  localparam int unsigned TM_EDGE   = 4;
  localparam int unsigned TM_ASSIGN = 3;
  localparam int unsigned TM_RATE_H = 2;
  localparam int unsigned PIN_EXT   = 2;
  localparam int unsigned PWR_WDT   = 7;
  localparam int unsigned PWR_EXT   = 6;
  localparam int unsigned PWR_LVD   = 5;
  localparam int unsigned NIB       = 4;

  typedef enum logic [6:0] {
    BR_NONE       = 7'h01,
    BR_SHORT_JUMP = 7'h02,
    BR_SHORT_CALL = 7'h04,
    BR_LONG_JUMP  = 7'h08,
    BR_LONG_CALL  = 7'h10,
    BR_RETURN     = 7'h20,
    BR_INT_RETURN = 7'h40
  } csr_branch_type;

  typedef enum logic [5:0] {
    ALU_NONE  = 6'h01,
    ALU_ADD   = 6'h02,
    ALU_SUB   = 6'h04,
    ALU_ROR   = 6'h08,
    ALU_ROL   = 6'h10,
    ALU_LOGIC = 6'h20
  } csr_alu_type;
endpackage : csr_pkg

// *** rtl/csr_core_regs.sv ***
// Special register set of the microcontroller core with its bus slave.
//
// Notes on behaviour
// - An indirect port access reaches the register chosen by the pointer.
// - Indirect access to the indirect port reads zero, writes change nothing.
// - Pointer bits five to zero select one of 64 registers.
// - Pointer bits seven and six always read as one.
// - The 8-bit timer counts instruction cycles or the pin, per source bit.
// - From the pin, the timer counts the rising or falling edge per edge bit.
// - Prescaler belongs to the timer when clear; timer writes then clear it.
// - Program counter is ten bits with a two-entry return stack.
// - Low counter byte is a register; bits nine and eight are hidden.
// - The counter advances by one each instruction unless loaded.
// - Short jump loads bits eight to zero, bit nine from the page flag.
// - Long jump and call load ten bits; the call also pushes.
// - Both return kinds pop the counter from the stack.
// - Flag writes lose to arithmetic updates; timeout and power-down never written.
// - Flag layout: carry, digit, zero, power-down, timeout, page, one general, wake type.
// - Carry from add, no-borrow on subtract, shifted bit on rotates.
// - Digit carry from the low nibble on add, nibble no-borrow on subtract.
// - Zero flag is set when a logic result is zero.
// - Power-down and timeout flags follow power-up, watchdog clear, sleep, timeout.
// - Wake type reads one after a port-change wake, zero after reset or any other wake.
// - Port reads give pin levels, writes go to the latch, top bits zero.
`timescale 1ns/1ps
module csr_core_regs
  import csr_pkg::*;
(
  // Clock, reset and enable.
  input  wire logic              CLOCK,
  input  wire logic              SYS_RST,
  input  wire logic              CLK_EN,
  // Avalon-MM register slave.
  input  wire logic [ADDR_W-1:0] AVS_ADDRESS,
  input  wire logic              AVS_READ,
  input  wire logic              AVS_WRITE,
  input  wire logic [31:0]       AVS_WRITEDATA,
  input  wire logic [3:0]        AVS_BYTEENABLE,
  output logic      [31:0]       AVS_READDATA,
  output logic                   AVS_WAITREQUEST,
  // Instruction execution side.
  input  wire logic              EXEC_VALID,
  input  csr_branch_type         EXEC_BRANCH,
  input  wire logic [PC_W-1:0]   EXEC_TARGET,
  input  csr_alu_type            ALU_OP,
  input  wire logic [7:0]        ALU_A,
  input  wire logic [7:0]        ALU_B,
  // Reset and power events.
  input  wire logic              EV_WDT_CLEAR,
  input  wire logic              EV_SLEEP,
  input  wire logic              EV_WDT_TIMEOUT,
  input  wire logic              EV_WAKE_PORT,
  input  wire logic              EV_WAKE_OTHER,
  // Port pins.
  input  wire logic [PORT_W-1:0] PORT_PIN,
  output logic      [PORT_W-1:0] PORT_OUT,
  // Core state.
  output logic      [PC_W-1:0]   PC_OUT,
  output logic      [7:0]        FLAGS_OUT,
  output logic      [7:0]        ALU_RESULT,
  output logic                   TIMER_OVF,
  output logic                   WDT_ENABLE,
  output logic                   EXT_INT_SELECT,
  output logic                   LVD_ENABLE
);

  typedef struct packed {
    logic [PORT_W-1:0]          pin_meta;
    logic [PORT_W-1:0]          pin_sync;
    logic                       ext_prev;
    logic [7:0]                 timer;
    logic [7:0]                 presc;
    logic                       ovf;
    logic [7:0]                 tmode;
    logic [7:0]                 flags;
    logic [7:0]                 ptr;
    logic [PORT_W-1:0]          latch;
    logic [7:0]                 power;
    logic [PC_W-1:0]            pc;
    logic [STK_D-1:0][PC_W-1:0] stack;
    logic [GEN_N-1:0][7:0]      gen;
    logic                       ack;
    logic [7:0]                 rdata;
    logic [7:0]                 alu_res;
  } csr_state_type;

  csr_state_type state_q;
  csr_state_type state_d;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic is_gen(input logic [IDX_W-1:0] i);
    return (i == IDX_GEN_SOLO) || ((i >= IDX_GEN_BASE) && (i <= IDX_GEN_LAST));
  endfunction : is_gen

  function automatic logic [7:0] rd_reg(input csr_state_type s,
                                        input logic [IDX_W-1:0] i);
    logic [7:0] v;
    v = 8'h00;
    if (is_gen(i)) begin
      v = s.gen[i[SEL_W-1:0]];
    end else begin
      unique case (i)
        IDX_TIMER:   v = s.timer;
        IDX_PCLOW:   v = s.pc[7:0];
        IDX_FLAGS:   v = s.flags;
        IDX_POINTER: v = s.ptr | POINTER_ONE;
        IDX_PORT:    v = {2'b00, s.pin_sync};
        IDX_POWER:   v = s.power | ~POWER_RW;
        IDX_TMODE:   v = s.tmode & TMODE_RW;
        default:     v = 8'h00;
      endcase
    end
    return v;
  endfunction : rd_reg

  ////////////////////////////////////////////////////////////////////////////
  logic              acc;
  logic [IDX_W-1:0]  idx;
  logic [IDX_W-1:0]  eff;
  logic [SEL_W-1:0]  slot;
  logic              ind_null;
  logic              bus_wr;
  logic [7:0]        wdata;
  logic              wr_timer;
  logic              wr_pcl;
  logic              wr_flags;
  logic              ext_edge;
  logic              src_evt;
  logic [7:0]        presc_mask;
  logic              tick;
  logic [8:0]        sum9;
  logic [8:0]        diff9;
  logic [NIB:0]      half9;
  logic              half_ok;
  logic [PC_W-1:0]   pc_next;
  logic              branching;

  assign acc       = AVS_READ | AVS_WRITE;
  assign idx       = AVS_ADDRESS[ADDR_W-1:IDX_LSB];
  assign slot      = state_q.ptr[SEL_W-1:0];
  assign ind_null  = (idx == IDX_INDIRECT) && (slot == PTR_NULL);
  assign eff       = (idx == IDX_INDIRECT) ? {1'b0, slot} : idx;
  assign bus_wr    = AVS_WRITE & state_q.ack & AVS_BYTEENABLE[0] & ~ind_null;
  assign wdata     = AVS_WRITEDATA[7:0];
  assign wr_timer  = bus_wr && (eff == IDX_TIMER);
  assign wr_pcl    = bus_wr && (eff == IDX_PCLOW);
  assign wr_flags  = bus_wr && (eff == IDX_FLAGS);
  // The pin edge is taken between the synchronised sample and its delayed copy.
  assign ext_edge  = state_q.tmode[TM_EDGE] ?
                     (state_q.ext_prev & ~state_q.pin_sync[PIN_EXT]) :
                     (~state_q.ext_prev & state_q.pin_sync[PIN_EXT]);
  assign src_evt   = state_q.tmode[TM_SRC] ? ext_edge : EXEC_VALID;
  assign presc_mask = (PRESC_BASE << state_q.tmode[TM_RATE_H:0]) - BYTE_ONE;
  assign tick      = src_evt && (state_q.tmode[TM_ASSIGN] ||
                     ((state_q.presc & presc_mask) == presc_mask));
  assign sum9      = {1'b0, ALU_A} + {1'b0, ALU_B};
  assign diff9     = {1'b0, ALU_A} - {1'b0, ALU_B};
  assign half9     = {1'b0, ALU_A[NIB-1:0]} + {1'b0, ALU_B[NIB-1:0]};
  assign half_ok   = ALU_A[NIB-1:0] >= ALU_B[NIB-1:0];
  assign pc_next   = state_q.pc + PC_ONE;
  assign branching = EXEC_VALID && (EXEC_BRANCH != BR_NONE);

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_d          = state_q;
    state_d.ovf      = 1'b0;
    state_d.ack      = acc & ~state_q.ack;
    state_d.pin_meta = PORT_PIN;
    state_d.pin_sync = state_q.pin_meta;
    state_d.ext_prev = state_q.pin_sync[PIN_EXT];
    if (acc && !state_q.ack) begin
      state_d.rdata = ind_null ? 8'h00 : rd_reg(state_q, eff);
    end

    // Prescaler and counter.
    if (src_evt && !state_q.tmode[TM_ASSIGN]) begin
      state_d.presc = state_q.presc + BYTE_ONE;
    end
    if (tick) begin
      state_d.timer = state_q.timer + BYTE_ONE;
      state_d.ovf   = (state_q.timer == TIMER_MAX);
    end
    if (wr_timer) begin
      state_d.timer = wdata;
      if (!state_q.tmode[TM_ASSIGN]) begin
        state_d.presc = '0;
      end
    end

    // Program counter and stack.
    if (EXEC_VALID) begin
      unique case (EXEC_BRANCH)
        BR_NONE: begin
          state_d.pc = pc_next;
        end
        BR_SHORT_JUMP: begin
          state_d.pc = {state_q.flags[FLG_PAGE], EXEC_TARGET[8:0]};
        end
        BR_SHORT_CALL: begin
          state_d.pc = {state_q.flags[FLG_PAGE], 1'b0, EXEC_TARGET[7:0]};
          state_d.stack = {state_q.stack[0], pc_next};
        end
        BR_LONG_JUMP: begin
          state_d.pc = EXEC_TARGET;
        end
        BR_LONG_CALL: begin
          state_d.pc    = EXEC_TARGET;
          state_d.stack = {state_q.stack[0], pc_next};
        end
        BR_RETURN, BR_INT_RETURN: begin
          state_d.pc       = state_q.stack[0];
          state_d.stack[0] = state_q.stack[1];
        end
        default: begin
          state_d.pc = pc_next;
        end
      endcase
    end
    if (wr_pcl && !branching) begin
      state_d.pc[7:0] = wdata;
    end

    // Bus writes to flags come first so that hardware updates win.
    if (wr_flags) begin
      state_d.flags[FLG_WAKE:FLG_PAGE] = wdata[FLG_WAKE:FLG_PAGE];
      if (ALU_OP == ALU_NONE) begin
        state_d.flags[FLG_ZERO:FLG_CARRY] = wdata[FLG_ZERO:FLG_CARRY];
      end
    end

    unique case (ALU_OP)
      ALU_NONE: begin
      end
      ALU_ADD: begin
        state_d.alu_res          = sum9[7:0];
        state_d.flags[FLG_CARRY] = sum9[8];
        state_d.flags[FLG_DIGIT] = half9[NIB];
        state_d.flags[FLG_ZERO]  = (sum9[7:0] == 8'h00);
      end
      ALU_SUB: begin
        state_d.alu_res          = diff9[7:0];
        state_d.flags[FLG_CARRY] = ~diff9[8];
        state_d.flags[FLG_DIGIT] = half_ok;
        state_d.flags[FLG_ZERO]  = (diff9[7:0] == 8'h00);
      end
      ALU_ROR: begin
        state_d.alu_res          = {state_q.flags[FLG_CARRY], ALU_A[7:1]};
        state_d.flags[FLG_CARRY] = ALU_A[0];
      end
      ALU_ROL: begin
        state_d.alu_res          = {ALU_A[6:0], state_q.flags[FLG_CARRY]};
        state_d.flags[FLG_CARRY] = ALU_A[7];
      end
      ALU_LOGIC: begin
        state_d.alu_res         = ALU_A;
        state_d.flags[FLG_ZERO] = (ALU_A == 8'h00);
      end
      default: begin
      end
    endcase

    // Clearing events are applied before setting events.
    if (EV_SLEEP) begin
      state_d.flags[FLG_PDOWN] = 1'b0;
    end
    if (EV_WDT_TIMEOUT) begin
      state_d.flags[FLG_TOUT] = 1'b0;
    end
    if (EV_WDT_CLEAR) begin
      state_d.flags[FLG_PDOWN] = 1'b1;
    end
    if (EV_WDT_CLEAR || EV_SLEEP) begin
      state_d.flags[FLG_TOUT] = 1'b1;
    end
    if (EV_WAKE_OTHER) begin
      state_d.flags[FLG_WAKE] = 1'b0;
    end
    if (EV_WAKE_PORT) begin
      state_d.flags[FLG_WAKE] = 1'b1;
    end

    // Remaining register writes.
    if (bus_wr) begin
      if (is_gen(eff)) begin
        state_d.gen[eff[SEL_W-1:0]] = wdata;
      end
      unique case (eff)
        IDX_POINTER: state_d.ptr   = wdata | POINTER_ONE;
        IDX_PORT:    state_d.latch = wdata[PORT_W-1:0] & LATCH_RW;
        IDX_POWER:   state_d.power = wdata & POWER_RW;
        IDX_TMODE:   state_d.tmode = wdata & TMODE_RW;
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      state_q       <= '0;
      state_q.flags <= RST_FLAGS;
      state_q.ptr   <= RST_POINTER;
      state_q.tmode <= RST_TMODE;
      state_q.power <= RST_POWER;
    end else if (CLK_EN) begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign AVS_WAITREQUEST = acc & ~state_q.ack;
  assign AVS_READDATA    = {24'h000000, state_q.rdata};
  assign PORT_OUT        = state_q.latch;
  assign PC_OUT          = state_q.pc;
  assign FLAGS_OUT       = state_q.flags;
  assign ALU_RESULT      = state_q.alu_res;
  assign TIMER_OVF       = state_q.ovf;
  assign WDT_ENABLE      = state_q.power[PWR_WDT];
  assign EXT_INT_SELECT  = state_q.power[PWR_EXT];
  assign LVD_ENABLE      = state_q.power[PWR_LVD];

  ////////////////////////////////////////////////////////////////////////////
  logic rd_done;
  assign rd_done = AVS_READ && !AVS_WAITREQUEST;

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);

  property p_ind_read;
    rd_done && (idx == IDX_INDIRECT) && is_gen(eff) |->
      AVS_READDATA[7:0] == state_q.gen[slot];
  endproperty
  a_ind_read: assert property (p_ind_read) else $error("indirect read wrong");

  property p_null_read;
    rd_done && ind_null |-> AVS_READDATA == 32'h00000000;
  endproperty
  a_null_read: assert property (p_null_read) else $error("null read not zero");

  property p_null_write;
    CLK_EN && AVS_WRITE && state_q.ack && ind_null |=>
      $stable(state_q.gen) && $stable(state_q.ptr);
  endproperty
  a_null_write: assert property (p_null_write) else $error("null write stored");

  property p_ptr_ones;
    rd_done && (idx == IDX_POINTER) |-> AVS_READDATA[7:6] == 2'b11;
  endproperty
  a_ptr_ones: assert property (p_ptr_ones) else $error("pointer top bits");

  property p_presc_clear;
    CLK_EN && wr_timer && !state_q.tmode[TM_ASSIGN] |=> state_q.presc == 8'h00;
  endproperty
  a_presc_clear: assert property (p_presc_clear) else $error("prescaler kept");

  property p_pc_inc;
    CLK_EN && EXEC_VALID && (EXEC_BRANCH == BR_NONE) && !wr_pcl |=>
      state_q.pc == $past(state_q.pc) + PC_ONE;
  endproperty
  a_pc_inc: assert property (p_pc_inc) else $error("pc did not advance");

  property p_short_call;
    CLK_EN && EXEC_VALID && (EXEC_BRANCH == BR_SHORT_CALL) |=>
      !state_q.pc[8] && (state_q.stack[0] == $past(pc_next)) &&
      (state_q.pc[7:0] == $past(EXEC_TARGET[7:0]));
  endproperty
  a_short_call: assert property (p_short_call) else $error("short call");

  property p_return;
    CLK_EN && EXEC_VALID && (EXEC_BRANCH == BR_RETURN) |=>
      state_q.pc == $past(state_q.stack[0]);
  endproperty
  a_return: assert property (p_return) else $error("return target");

  property p_carry_add;
    CLK_EN && (ALU_OP == ALU_ADD) |=> FLAGS_OUT[FLG_CARRY] == $past(ALU_A > ~ALU_B);
  endproperty
  a_carry_add: assert property (p_carry_add) else $error("add carry");

  property p_sleep_pd;
    CLK_EN && EV_SLEEP && !EV_WDT_CLEAR |=>
      !FLAGS_OUT[FLG_PDOWN] && FLAGS_OUT[FLG_TOUT];
  endproperty
  a_sleep_pd: assert property (p_sleep_pd) else $error("sleep flags");

  property p_wrap;
    CLK_EN && tick && (state_q.timer == TIMER_MAX) && !wr_timer |=>
      (state_q.timer == 8'h00) && TIMER_OVF ##1 (!TIMER_OVF || !$past(CLK_EN));
  endproperty
  a_wrap: assert property (p_wrap) else $error("timer wrap");

  c_call_ret: cover property (EXEC_VALID && (EXEC_BRANCH == BR_SHORT_CALL)
    ##[1:20] EXEC_VALID && (EXEC_BRANCH == BR_RETURN));
  c_ovf: cover property (TIMER_OVF);
  c_ind: cover property (rd_done && (idx == IDX_INDIRECT) && !ind_null);
endmodule : csr_core_regs

// *** sim/csr_core_regs_test.sv ***
// Self-checking testbench for the core special register block.
`timescale 1ns/1ps
module csr_core_regs_test
  import csr_pkg::*;
();
  typedef struct packed {
    csr_alu_type op;
    logic [7:0]  a;
    logic [7:0]  b;
    logic [7:0]  res;
    logic [2:0]  fl;
    logic [2:0]  msk;
    logic        rchk;
  } csr_row_type;

  logic              clock;
  logic              sys_rst;
  logic [ADDR_W-1:0] avs_address;
  logic              avs_read;
  logic              avs_write;
  logic [31:0]       avs_writedata;
  logic [31:0]       avs_readdata;
  logic              avs_waitrequest;
  logic              exec_valid;
  csr_branch_type    exec_branch;
  logic [PC_W-1:0]   exec_target;
  csr_alu_type       alu_op;
  logic [7:0]        alu_a;
  logic [7:0]        alu_b;
  logic [4:0]        ev;
  logic [PORT_W-1:0] port_pin;
  logic              clk_en;
  logic [3:0]        byte_en;
  logic [PORT_W-1:0] port_out;
  logic [PC_W-1:0]   pc_out;
  logic [7:0]        flags_out;
  logic [7:0]        alu_result;
  logic              timer_ovf;
  logic              wdt_en;
  logic              ext_sel;
  logic              lvd_en;
  int                n_errors;
  int                n_tests;
  int                ovf_cnt;
  logic [PC_W-1:0]   pc;
  logic [PC_W-1:0]   s0;
  logic [PC_W-1:0]   s1;
  logic              f5;
  logic [7:0]        rd;
  logic [2:0]        evx [5] = '{3'h2, 3'h0, 3'h3, 3'h7, 3'h3};
  // Operation, operands, result, flags {zero, digit, carry}, flag mask, result check.
  csr_row_type       rows [10] = '{
    '{ALU_ADD, 8'h0f, 8'h01, 8'h10, 3'h2, 3'h7, 1'b1},
    '{ALU_ADD, 8'hff, 8'h01, 8'h00, 3'h7, 3'h7, 1'b1},
    '{ALU_ADD, 8'h70, 8'ha0, 8'h10, 3'h1, 3'h7, 1'b1},
    '{ALU_SUB, 8'h10, 8'h01, 8'h0f, 3'h1, 3'h7, 1'b1},
    '{ALU_SUB, 8'h01, 8'h02, 8'hff, 3'h0, 3'h7, 1'b1},
    '{ALU_SUB, 8'h35, 8'h35, 8'h00, 3'h7, 3'h7, 1'b1},
    '{ALU_ROR, 8'h01, 8'h00, 8'h80, 3'h1, 3'h1, 1'b1},
    '{ALU_ROL, 8'h40, 8'h00, 8'h81, 3'h0, 3'h1, 1'b1},
    '{ALU_LOGIC, 8'h00, 8'h00, 8'h00, 3'h4, 3'h4, 1'b1},
    '{ALU_LOGIC, 8'h5a, 8'h00, 8'h5a, 3'h0, 3'h4, 1'b1}};

  csr_core_regs u_csr_core_regs (
    .CLOCK(clock), .SYS_RST(sys_rst), .CLK_EN(clk_en),
    .AVS_ADDRESS(avs_address), .AVS_READ(avs_read), .AVS_WRITE(avs_write),
    .AVS_WRITEDATA(avs_writedata), .AVS_BYTEENABLE(byte_en), .AVS_READDATA(avs_readdata),
    .AVS_WAITREQUEST(avs_waitrequest), .EXEC_VALID(exec_valid), .EXEC_BRANCH(exec_branch),
    .EXEC_TARGET(exec_target), .ALU_OP(alu_op), .ALU_A(alu_a), .ALU_B(alu_b),
    .EV_WDT_CLEAR(ev[2]), .EV_SLEEP(ev[0]), .EV_WDT_TIMEOUT(ev[1]),
    .EV_WAKE_PORT(ev[3]), .EV_WAKE_OTHER(ev[4]), .PORT_PIN(port_pin), .PORT_OUT(port_out),
    .PC_OUT(pc_out), .FLAGS_OUT(flags_out), .ALU_RESULT(alu_result), .TIMER_OVF(timer_ovf),
    .WDT_ENABLE(wdt_en), .EXT_INT_SELECT(ext_sel), .LVD_ENABLE(lvd_en));

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  always @(posedge clock) begin
    if (timer_ovf === 1'b1) begin
      ovf_cnt++;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task test_done();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : test_done

  // One Avalon access; called just after a rising edge, returns just after one.
  task bus(input logic wr, input logic [6:0] idx, input logic [7:0] wd);
    int k;
    avs_address   <= {idx, 2'b00};
    avs_writedata <= {24'h000000, wd};
    avs_write     <= wr;
    avs_read      <= ~wr;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 20);
    if (avs_waitrequest !== 1'b0) begin
      n_errors++;
      $display("CHECK FAILED waitrequest expected 0 seen %b", avs_waitrequest);
      test_done();
    end
    rd = avs_readdata[7:0];
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clock);
  endtask : bus

  task wr(input logic [6:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d);
  endtask : wr

  task rdc(input string nm, input logic [6:0] idx, input logic [7:0] e);
    bus(1'b0, idx, 8'h00);
    chk(nm, {8'h00, e}, {8'h00, rd});
  endtask : rdc

  // Runs one instruction cycle and follows the counter and return stack.
  task exec(input csr_branch_type br, input logic [PC_W-1:0] t);
    logic [PC_W-1:0] npc;
    npc = pc + 10'h001;
    case (br)
      BR_SHORT_JUMP: npc = {f5, t[8:0]};
      BR_SHORT_CALL, BR_LONG_CALL: begin
        npc = (br == BR_LONG_CALL) ? t : {f5, 1'b0, t[7:0]};
        s1 = s0;
        s0 = pc + 10'h001;
      end
      BR_LONG_JUMP: npc = t;
      BR_RETURN, BR_INT_RETURN: begin
        npc = s0;
        s0 = s1;
      end
      default: npc = pc + 10'h001;
    endcase
    exec_valid  <= 1'b1;
    exec_branch <= br;
    exec_target <= t;
    @(posedge clock);
    exec_valid  <= 1'b0;
    exec_branch <= BR_NONE;
    @(posedge clock);
    pc = npc;
    chk("program counter", {6'h00, pc}, {6'h00, pc_out});
  endtask : exec

  task pin_step(input logic [5:0] v, input string nm, input logic [7:0] e);
    port_pin <= v;
    repeat (6) @(posedge clock);
    rdc(nm, IDX_TIMER, e);
  endtask : pin_step

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    n_errors = 0; n_tests = 0; ovf_cnt = 0; pc = '0; s0 = '0; s1 = '0; f5 = 1'b0;
    sys_rst = 1'b1; avs_address = '0; avs_read = 1'b0; avs_write = 1'b0;
    avs_writedata = '0; exec_valid = 1'b0; exec_branch = BR_NONE; exec_target = '0;
    alu_op = ALU_NONE; alu_a = 8'h00; alu_b = 8'h00; ev = 5'h00; port_pin = 6'h00;
    clk_en = 1'b1;
    byte_en = 4'h1;
    repeat (20) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    rdc("flags reset", IDX_FLAGS, 8'h18);
    rdc("pointer reset", IDX_POINTER, 8'hc0);
    rdc("pc low reset", IDX_PCLOW, 8'h00);
    chk("power reset", 16'h0005, {13'h0000, wdt_en, ext_sel, lvd_en});
    $display("reset test done");
    for (int i = 0; i < 10; i++) begin
      alu_op <= rows[i].op;
      alu_a  <= rows[i].a;
      alu_b  <= rows[i].b;
      @(posedge clock);
      alu_op <= ALU_NONE;
      @(posedge clock);
      chk("alu flags", {13'h0000, rows[i].fl}, {13'h0000, flags_out[2:0] & rows[i].msk});
      if (rows[i].rchk) begin
        chk("alu result", {8'h00, rows[i].res}, {8'h00, alu_result});
      end
    end
    $display("alu table test done");
    wr(IDX_FLAGS, 8'h27);
    rdc("flags write", IDX_FLAGS, 8'h3f);
    alu_op <= ALU_ADD;
    alu_a  <= 8'h01;
    alu_b  <= 8'h01;
    wr(IDX_FLAGS, 8'he7);
    alu_op <= ALU_NONE;
    rdc("flags under alu", IDX_FLAGS, 8'hf8);
    wr(IDX_FLAGS, 8'h20);
    f5 = 1'b1;
    for (int i = 0; i < 5; i++) begin
      ev <= 5'h01 << i;
      @(posedge clock);
      ev <= 5'h00;
      @(posedge clock);
      chk("event flags", {13'h0000, evx[i]}, {13'h0000, flags_out[7], flags_out[4:3]});
    end
    $display("flags test done");
    exec(BR_NONE, 10'h000);
    exec(BR_SHORT_JUMP, 10'h155);
    exec(BR_SHORT_CALL, 10'h3ab);
    exec(BR_LONG_CALL, 10'h123);
    exec(BR_LONG_JUMP, 10'h0f0);
    exec(BR_RETURN, 10'h000);
    exec(BR_INT_RETURN, 10'h000);
    rdc("pc low read", IDX_PCLOW, pc[7:0]);
    wr(IDX_PCLOW, 8'h40);
    pc = {pc[9:8], 8'h40};
    chk("pc low write", {6'h00, pc}, {6'h00, pc_out});
    $display("program counter test done");
    wr(IDX_GEN_LAST, 8'h3a);
    wr(IDX_POINTER, 8'h3f);
    rdc("pointer top", IDX_POINTER, 8'hff);
    rdc("indirect read", IDX_INDIRECT, 8'h3a);
    wr(IDX_INDIRECT, 8'h55);
    rdc("indirect write", IDX_GEN_LAST, 8'h55);
    wr(IDX_POINTER, 8'h02);
    rdc("indirect special", IDX_INDIRECT, pc[7:0]);
    wr(IDX_POINTER, 8'h00);
    rdc("null read", IDX_INDIRECT, 8'h00);
    wr(IDX_INDIRECT, 8'h99);
    rdc("null write pointer", IDX_POINTER, 8'hc0);
    rdc("null write target", IDX_GEN_LAST, 8'h55);
    wr(7'h05, 8'haa);
    rdc("unmapped", 7'h05, 8'h00);
    $display("indirect test done");
    port_pin <= 6'h2a;
    repeat (4) @(posedge clock);
    rdc("port pins", IDX_PORT, 8'h2a);
    wr(IDX_PORT, 8'hff);
    chk("port latch", 16'h0037, {10'h000, port_out});
    wr(IDX_POWER, 8'h40);
    chk("power write", 16'h0002, {13'h0000, wdt_en, ext_sel, lvd_en});
    byte_en <= 4'h0;
    wr(IDX_GEN_SOLO, 8'h77);
    byte_en <= 4'h1;
    rdc("byte enable", IDX_GEN_SOLO, 8'h00);
    // With the enable low an instruction cycle must leave the counter alone.
    clk_en     <= 1'b0;
    exec_valid <= 1'b1;
    repeat (3) @(posedge clock);
    exec_valid <= 1'b0;
    clk_en     <= 1'b1;
    @(posedge clock);
    chk("enable freeze", {6'h00, pc}, {6'h00, pc_out});
    $display("port test done");
    wr(IDX_TMODE, 8'h08);
    wr(IDX_TIMER, 8'hfd);
    ovf_cnt = 0;
    repeat (3) exec(BR_NONE, 10'h000);
    rdc("timer wrap", IDX_TIMER, 8'h00);
    chk("overflow pulses", 16'h0001, ovf_cnt[15:0]);
    wr(IDX_TMODE, 8'h00);
    wr(IDX_TIMER, 8'h00);
    exec(BR_NONE, 10'h000);
    wr(IDX_TIMER, 8'h10);
    exec(BR_NONE, 10'h000);
    rdc("prescaler cleared", IDX_TIMER, 8'h10);
    exec(BR_NONE, 10'h000);
    rdc("prescaled count", IDX_TIMER, 8'h11);
    wr(IDX_TMODE, 8'h28);
    wr(IDX_TIMER, 8'h00);
    pin_step(6'h2e, "rising edge", 8'h01);
    wr(IDX_TMODE, 8'h38);
    wr(IDX_TIMER, 8'h00);
    pin_step(6'h2a, "falling edge", 8'h01);
    pin_step(6'h2e, "rising ignored", 8'h01);
    $display("timer test done");
    sys_rst <= 1'b1;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    chk("pc second reset", 16'h0000, {6'h00, pc_out});
    chk("flags second reset", 16'h0018, {8'h00, flags_out});
    rdc("pointer second reset", IDX_POINTER, 8'hc0);
    $display("second reset test done");
    test_done();
  end

  initial begin
    repeat (20000) @(posedge clock);
    n_errors++;
    $display("CHECK FAILED run length expected end seen limit");
    test_done();
  end
endmodule : csr_core_regs_test
